// ---- rtl/adcid_cfg.svh ----
// Register indices, field positions, reset values and constants of the ID/status bank
`ifndef ADCID_CFG_SVH
`define ADCID_CFG_SVH

// Register indices; byte address is four times the index
`define ADCID_IDX_ID 6'h00
`define ADCID_IDX_STATUS 6'h01
`define ADCID_IDX_MODE 6'h02
`define ADCID_IDX_IRQ_STS 6'h20
`define ADCID_IDX_IRQ_MASK 6'h21

// Identification word
// Arbitrary neutral value for the fixed top nibble
`define ADCID_ID_UPPER 4'h6
`define ADCID_CHAN_COUNT 4'h4
// Arbitrary neutral value for the version-dependent low byte
`define ADCID_ID_LOW 8'h5a

// Status and mode field positions
`define ADCID_B_LOCK 15
`define ADCID_B_RESYNC 14
`define ADCID_B_REGMAP 13
`define ADCID_B_CRCERR 12
`define ADCID_B_CRCTYPE 11
`define ADCID_B_RSTFLAG 10
`define ADCID_B_WLEN_HI 9
`define ADCID_B_WLEN_LO 8

// Reset values
`define ADCID_STATUS_RST 16'h0500
`define ADCID_MODE_RST 16'h0510
// Reserved mode bits 15:14, 7:5, 3:2 read back as zero
`define ADCID_MODE_WMASK 16'h3f13
`define ADCID_IRQ_MASK_RST 7'h00

// CRC polynomials
`define ADCID_POLY_CCITT 16'h1021
`define ADCID_POLY_ANSI 16'h8005

`endif

// ---- rtl/adcid_pkg.sv ----
// Types shared by the ID/status register bank
package adcid_pkg;
    typedef logic [15:0] adcid_word_t;
    typedef logic [7:0] adcid_addr_t;
    typedef logic [6:0] adcid_irq_t;
    typedef logic [3:0] adcid_chan_t;
    typedef enum logic [1:0] {
        ADCID_WL_16 = 2'b00,
        ADCID_WL_24 = 2'b01,
        ADCID_WL_32_PAD = 2'b10,
        ADCID_WL_32_SEXT = 2'b11
    } adcid_wlen_t;
endpackage : adcid_pkg

// ---- rtl/adcid_regs.sv ----
// APB register bank with identification, status and mode words of a four-channel ADC
`timescale 1ns/1ps
`default_nettype none
`include "adcid_cfg.svh"

module adcid_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire adcid_pkg::adcid_addr_t paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter events, same clock domain
    input wire logic link_locked,
    input wire logic resync_event,
    input wire logic regmap_crc_changed,
    input wire logic rx_crc_error,
    input wire adcid_pkg::adcid_chan_t new_sample,
    input wire adcid_pkg::adcid_chan_t sample_taken,
    // Settings towards the data path
    output adcid_pkg::adcid_wlen_t sample_word_size_field,
    output logic [15:0] crc_poly,
    output logic [15:0] mode_word,
    // Interrupt
    output logic irq
);
    import adcid_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic adcid_addr_t byte_addr(input logic [5:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction : byte_addr

    function automatic logic [15:0] poly_of(input logic crc_ansi);
        poly_of = crc_ansi ? `ADCID_POLY_ANSI : `ADCID_POLY_CCITT;
    endfunction : poly_of

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic setup_ph;
    wire logic access_ph;
    wire logic rd_done;
    wire logic wr_done;
    wire logic hit_id;
    wire logic hit_sts;
    wire logic hit_mode;
    wire logic hit_ists;
    wire logic hit_imask;
    wire logic hit_any;

    assign setup_ph = psel & ~penable;
    // Zero wait states: pready is raised for the first access cycle
    assign access_ph = psel & penable & pready;
    assign rd_done = access_ph & ~pwrite & ~pslverr;
    assign wr_done = access_ph & pwrite & ~pslverr;
    assign hit_id = paddr == byte_addr(`ADCID_IDX_ID);
    assign hit_sts = paddr == byte_addr(`ADCID_IDX_STATUS);
    assign hit_mode = paddr == byte_addr(`ADCID_IDX_MODE);
    assign hit_ists = paddr == byte_addr(`ADCID_IDX_IRQ_STS);
    assign hit_imask = paddr == byte_addr(`ADCID_IDX_IRQ_MASK);
    assign hit_any = hit_id | hit_sts | hit_mode | hit_ists | hit_imask;

    // Writes to read-only words are refused with an error too
    wire logic bad_acc;
    assign bad_acc = ~hit_any | (pwrite & (hit_id | hit_sts | hit_ists));

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic lock_q;
    logic resync_q;
    logic resync_d;
    logic regmap_q;
    logic regmap_d;
    logic crcerr_q;
    logic crcerr_d;
    adcid_chan_t drdy_q;
    adcid_chan_t drdy_d;
    adcid_word_t mode_q;
    adcid_word_t mode_d;
    adcid_irq_t ists_q;
    adcid_irq_t ists_d;
    adcid_irq_t imask_q;
    adcid_irq_t ev_vec;

    wire logic sts_rd;
    wire logic ists_rd;
    wire logic mode_wr;
    wire logic imask_wr;
    assign sts_rd = rd_done & hit_sts;
    assign ists_rd = rd_done & hit_ists;
    assign mode_wr = wr_done & hit_mode;
    assign imask_wr = wr_done & hit_imask;

    // Event sources; a set in the clearing cycle survives
    assign ev_vec = {new_sample, rx_crc_error, regmap_crc_changed, resync_event};

    // A read clears only the flags that it returned; one set in the setup cycle
    // missed the snapshot in prdata and has to survive the read
    wire adcid_word_t seen_sts;
    wire adcid_irq_t seen_irq;
    assign seen_sts = prdata[15:0] & {16{sts_rd}};
    assign seen_irq = prdata[6:0] & {7{ists_rd}};

    assign resync_d = resync_event | (resync_q & ~seen_sts[`ADCID_B_RESYNC]);
    assign regmap_d = regmap_crc_changed | (regmap_q & ~seen_sts[`ADCID_B_REGMAP]);
    assign crcerr_d = rx_crc_error | (crcerr_q & ~seen_sts[`ADCID_B_CRCERR]);
    assign drdy_d = new_sample | (drdy_q & ~sample_taken);
    assign ists_d = ev_vec | (ists_q & ~seen_irq);

    // Reserved mode bits are kept at zero whatever is written
    assign mode_d = mode_wr ? (pwdata[15:0] & `ADCID_MODE_WMASK) : mode_q;

    // ------------------------------------------------------------
    // Status and identification words
    // ------------------------------------------------------------
    wire adcid_word_t id_word;
    wire adcid_word_t sts_word;

    assign id_word = {`ADCID_ID_UPPER, `ADCID_CHAN_COUNT, `ADCID_ID_LOW};
    assign sts_word = {
        lock_q,
        resync_q,
        regmap_q,
        crcerr_q,
        mode_q[`ADCID_B_CRCTYPE],
        mode_q[`ADCID_B_RSTFLAG],
        mode_q[`ADCID_B_WLEN_HI:`ADCID_B_WLEN_LO],
        4'h0,
        drdy_q
    };

    wire adcid_word_t rd_mux;
    assign rd_mux = hit_id ? id_word :
                    hit_sts ? sts_word :
                    hit_mode ? mode_q :
                    hit_ists ? {9'h000, ists_q} :
                    hit_imask ? {9'h000, imask_q} : 16'h0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_q <= 1'b0;
            resync_q <= 1'b0;
            regmap_q <= 1'b0;
            crcerr_q <= 1'b0;
            drdy_q <= 4'h0;
        end else begin
            lock_q <= link_locked;
            resync_q <= resync_d;
            regmap_q <= regmap_d;
            crcerr_q <= crcerr_d;
            drdy_q <= drdy_d;
        end
    end

    // Reset flag, CRC type and word length start from the mode reset value
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_q <= `ADCID_MODE_RST;
            ists_q <= `ADCID_IRQ_MASK_RST;
            imask_q <= `ADCID_IRQ_MASK_RST;
        end else begin
            mode_q <= mode_d;
            ists_q <= ists_d;
            imask_q <= imask_wr ? pwdata[6:0] : imask_q;
        end
    end

    // Answer is loaded in the setup cycle and held through the access cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & bad_acc;
            prdata <= (setup_ph & ~pwrite & ~bad_acc) ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sample_word_size_field <= ADCID_WL_24;
            crc_poly <= `ADCID_POLY_CCITT;
            mode_word <= `ADCID_MODE_RST;
            irq <= 1'b0;
        end else begin
            sample_word_size_field <= adcid_wlen_t'(mode_q[`ADCID_B_WLEN_HI:`ADCID_B_WLEN_LO]);
            crc_poly <= poly_of(mode_q[`ADCID_B_CRCTYPE]);
            mode_word <= mode_q;
            irq <= |(ists_d & imask_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_id_count;
        @(posedge clk) disable iff (srst)
        setup_ph && !pwrite && hit_id |=> prdata[11:8] == 4'h4 && pready;
    endproperty
    a_id_count: assert property (p_id_count) else $error("channel count not four");

    property p_lock;
        @(posedge clk) disable iff (srst)
        link_locked |=> sts_word[15] ##1 (sts_word[15] == $past(link_locked));
    endproperty
    a_lock: assert property (p_lock) else $error("lock bit does not follow lock");

    property p_resync;
        @(posedge clk) disable iff (srst)
        resync_event |=> sts_word[14] && (irq || !$past(imask_q[0]));
    endproperty
    a_resync: assert property (p_resync) else $error("resync flag not set");

    property p_resync_hold;
        @(posedge clk) disable iff (srst)
        resync_q && !sts_rd |=> sts_word[14];
    endproperty
    a_resync_hold: assert property (p_resync_hold) else $error("resync flag lost");

    property p_regmap;
        @(posedge clk) disable iff (srst)
        regmap_crc_changed |=> sts_word[13];
    endproperty
    a_regmap: assert property (p_regmap) else $error("map crc flag not set");

    property p_crcerr;
        @(posedge clk) disable iff (srst)
        sts_rd && prdata[12] && !rx_crc_error |=> !sts_word[12];
    endproperty
    a_crcerr: assert property (p_crcerr) else $error("crc error flag not cleared by read");

    property p_crc_hold;
        @(posedge clk) disable iff (srst)
        crcerr_q && !sts_rd |=> sts_word[12];
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("crc error flag lost");

    property p_rstflag;
        @(posedge clk) disable iff (srst)
        $past(srst) |-> sts_word == `ADCID_STATUS_RST;
    endproperty
    a_rstflag: assert property (p_rstflag) else $error("status reset value wrong");

    property p_wlen;
        @(posedge clk) disable iff (srst)
        mode_wr |=> sts_word[9:8] == $past(pwdata[9:8])
            ##1 sample_word_size_field == $past(sts_word[9:8]);
    endproperty
    a_wlen: assert property (p_wlen) else $error("word length not mirrored");

    property p_reserved;
        @(posedge clk) disable iff (srst)
        setup_ph && !pwrite && hit_sts |=> prdata[7:4] == 4'h0 && prdata[15:0] == $past(sts_word);
    endproperty
    a_reserved: assert property (p_reserved) else $error("status read wrong");

    property p_drdy;
        @(posedge clk) disable iff (srst)
        |new_sample |=> (sts_word[3:0] & $past(new_sample)) == $past(new_sample);
    endproperty
    a_drdy: assert property (p_drdy) else $error("new-data flag lost");

    property p_drdy_keep;
        @(posedge clk) disable iff (srst)
        drdy_q[0] && !sample_taken[0] |=> sts_word[0];
    endproperty
    a_drdy_keep: assert property (p_drdy_keep) else $error("new-data flag dropped");

    property p_sts_ro;
        @(posedge clk) disable iff (srst)
        setup_ph && pwrite && hit_sts |=> pready && pslverr && prdata == 32'h0000_0000;
    endproperty
    a_sts_ro: assert property (p_sts_ro) else $error("status write not refused");

    property p_poly;
        @(posedge clk) disable iff (srst)
        mode_wr ##1 1'b1 |=> crc_poly == ($past(pwdata[11], 2) ? 16'h8005 : 16'h1021);
    endproperty
    a_poly: assert property (p_poly) else $error("crc polynomial mismatch");

endmodule : adcid_regs

`default_nettype wire

// ---- test/adcid_host.sv ----
// APB host model that reaches the ID/status register bank
`timescale 1ns/1ps
`default_nettype none
module adcid_host (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output adcid_pkg::adcid_addr_t paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import adcid_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic wr, input adcid_addr_t a, input logic [31:0] d,
                        output logic [31:0] rdata, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value is never taken for a live one
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
    // Only the upper byte is trusted; the low byte may differ between versions
    function automatic logic [31:0] id_upper(logic [31:0] w);
        return {24'h0, w[15:8]};
    endfunction : id_upper
    // Mode word with the reset flag written as zero, which clears it in status
    function automatic logic [31:0] mode_val(logic crc, logic [1:0] wl);
        return {20'h0, crc, 1'b0, wl, 8'h10};
    endfunction : mode_val
endmodule : adcid_host
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the ID/status register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import adcid_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic link_locked = 1'b0;
    logic resync_event = 1'b0;
    logic regmap_crc_changed = 1'b0;
    logic rx_crc_error = 1'b0;
    adcid_chan_t new_sample = 4'h0;
    adcid_chan_t sample_taken = 4'h0;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    adcid_addr_t paddr;
    logic [31:0] pwdata, prdata, rd;
    adcid_wlen_t sample_word_size_field;
    logic [15:0] crc_poly, mode_word;
    int n_errors = 0;
    int total_checks = 0;
    always #2.5 clk = ~clk;
    adcid_regs dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_locked(link_locked), .resync_event(resync_event),
        .regmap_crc_changed(regmap_crc_changed), .rx_crc_error(rx_crc_error),
        .new_sample(new_sample), .sample_taken(sample_taken),
        .sample_word_size_field(sample_word_size_field), .crc_poly(crc_poly),
        .mode_word(mode_word), .irq(irq));
    adcid_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd_chk(string what, adcid_addr_t a, logic [31:0] exp, logic eerr);
        host.xfer(1'b0, a, 32'h0, rd, err);
        check(what, rd, exp);
        check({what, " err"}, {31'h0, err}, {31'h0, eerr});
    endtask : rd_chk
    task automatic wr(adcid_addr_t a, logic [31:0] d, logic eerr);
        host.xfer(1'b1, a, d, rd, err);
        check("write err", {31'h0, err}, {31'h0, eerr});
    endtask : wr
    task automatic pulse(logic [2:0] ev, adcid_chan_t ns, adcid_chan_t st);
        @(posedge clk);
        {resync_event, regmap_crc_changed, rx_crc_error} <= ev;
        new_sample <= ns;
        sample_taken <= st;
        @(posedge clk);
        {resync_event, regmap_crc_changed, rx_crc_error} <= 3'b000;
        new_sample <= 4'h0;
        sample_taken <= 4'h0;
        repeat (2) @(posedge clk);
    endtask : pulse
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        check("irq after reset", {31'h0, irq}, 32'h0);
        rd_chk("status reset", 8'h04, 32'h0500, 1'b0);
        host.xfer(1'b0, 8'h00, 32'h0, rd, err);
        check("channel count", host.id_upper(rd) & 32'h0000_000f, 32'h4);
        $display("test reset done");
    endtask : t_reset
    task automatic t_events;
        @(posedge clk);
        link_locked <= 1'b1;
        pulse(3'b111, 4'hf, 4'h0);
        rd_chk("status events", 8'h04, 32'hf50f, 1'b0);
        rd_chk("status cleared", 8'h04, 32'h850f, 1'b0);
        pulse(3'b000, 4'h0, 4'h5);
        rd_chk("status taken", 8'h04, 32'h850a, 1'b0);
        @(posedge clk);
        link_locked <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk("status unlocked", 8'h04, 32'h050a, 1'b0);
        $display("test events done");
    endtask : t_events
    task automatic t_mode;
        for (int k = 0; k < 4; k++) begin
            wr(8'h08, host.mode_val(1'b1, k[1:0]), 1'b0);
            repeat (2) @(posedge clk);
            check("word size", {30'h0, sample_word_size_field}, k);
            check("poly ansi", {16'h0, crc_poly}, 32'h8005);
            check("mode copy", {16'h0, mode_word}, host.mode_val(1'b1, k[1:0]));
            rd_chk("status mode", 8'h04, {20'h0, 2'b10, k[1:0], 8'h0a}, 1'b0);
        end
        wr(8'h08, 32'h0510, 1'b0);
        repeat (2) @(posedge clk);
        check("poly ccitt", {16'h0, crc_poly}, 32'h1021);
        rd_chk("status back", 8'h04, 32'h050a, 1'b0);
        rd_chk("mode back", 8'h08, 32'h0510, 1'b0);
        $display("test mode done");
    endtask : t_mode
    task automatic t_refused;
        wr(8'h04, 32'h0, 1'b1);
        wr(8'h00, 32'hffff, 1'b1);
        rd_chk("status kept", 8'h04, 32'h050a, 1'b0);
        rd_chk("unmapped", 8'h40, 32'h0, 1'b1);
        $display("test refused done");
    endtask : t_refused
    task automatic t_irq;
        rd_chk("irq status all", 8'h80, 32'h7f, 1'b0);
        wr(8'h84, 32'h0, 1'b0);
        pulse(3'b100, 4'h0, 4'h0);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(8'h84, 32'h1, 1'b0);
        repeat (2) @(posedge clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        rd_chk("irq status", 8'h80, 32'h1, 1'b0);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask : t_irq
    initial begin
        t_reset();
        t_events();
        t_mode();
        t_refused();
        t_irq();
        t_reset();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        summarize();
    end
endmodule : tb
`default_nettype wire
